// *** rtl/afex_host_ctrl.sv ***
// host controller driving one or more asynchronous fifo devices through their strobe pins
`default_nettype none
module afex_host_ctrl (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire afex_pkg::afex_mode_t mode_in,
    input wire logic reset_req_in,
    input wire logic retransmit_req_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [afex_pkg::WORD_W-1:0] wr_data_in,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [afex_pkg::WORD_W-1:0] rd_data_out,
    output afex_pkg::afex_pins_t dev_pins_out,
    input wire afex_pkg::afex_flags_t dev_flags_in,
    input wire logic [afex_pkg::WORD_W-1:0] dev_q_in,
    output logic chain_strap_n_out,
    output logic chain_strap_oe_out,
    output logic empty_out,
    output logic full_out,
    output logic half_full_out,
    output logic retransmit_refused_out,
    output logic busy_out
);
    // every device operation is a low phase then a settle phase; the settle covers
    // the device flag delay plus the two synchroniser stages before flags are trusted
    typedef enum logic [3:0] {
        ST_RESET_LOW,
        ST_RESET_REC,
        ST_IDLE,
        ST_WR_LOW,
        ST_WR_HIGH,
        ST_RD_LOW,
        ST_RD_HIGH,
        ST_RT_LOW,
        ST_RT_HIGH
    } afex_state_t;

    afex_state_t state;
    afex_state_t next_state;
    logic [afex_pkg::CNT_W-1:0] cnt;
    logic [afex_pkg::CNT_W-1:0] next_cnt;
    afex_pkg::afex_mode_t mode;
    afex_pkg::afex_pins_t pins;
    afex_pkg::afex_flags_t flags_s1;
    afex_pkg::afex_flags_t flags_s2;
    logic [afex_pkg::WORD_W-1:0] q_s1;
    logic [afex_pkg::WORD_W-1:0] q_s2;
    logic [afex_pkg::WORD_W-1:0] rd_data;
    logic rd_valid;
    logic reset_pend;
    logic rt_pend;
    logic prefer_read;
    logic rt_refused;

    // write buffer
    wire buf_valid;
    wire [afex_pkg::WORD_W-1:0] buf_data;
    wire start_write;

    afex_buf #(
        .WIDTH(afex_pkg::WORD_W),
        .DEPTH(afex_pkg::BUF_DEPTH)
    ) u_wr_buf (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(wr_valid_in),
        .in_ready_out(wr_ready_out),
        .in_data_in(wr_data_in),
        .out_valid_out(buf_valid),
        .out_ready_in(start_write),
        .out_data_out(buf_data)
    );

    // mode decode
    wire depth_mode = (mode == afex_pkg::AFEX_MODE_DEPTH);
    wire width_mode = (mode == afex_pkg::AFEX_MODE_WIDTH);

    // composite flags from the synchronised device flags
    wire comp_empty_n = depth_mode ? |flags_s2.empty_flag_n : flags_s2.empty_flag_n[0];
    wire comp_full_n = depth_mode ? |flags_s2.full_flag_n : flags_s2.full_flag_n[0];
    // no half-full in depth mode, chain-out is then a chain signal
    wire comp_half_n = depth_mode ? 1'b1 : flags_s2.chain_out_n[0];

    // request selection in idle
    wire idle = (state == ST_IDLE);
    wire can_write = buf_valid && comp_full_n;
    wire can_read = comp_empty_n && !rd_valid;
    wire take_reset = idle && reset_pend;
    wire take_rt = idle && !reset_pend && rt_pend && !depth_mode;
    wire drop_rt = idle && !reset_pend && rt_pend && depth_mode;
    wire arb_free = idle && !reset_pend && !rt_pend;
    // read and write alternate so a steady writer cannot starve the reader
    wire start_read = arb_free && can_read && (prefer_read || !can_write);
    assign start_write = arb_free && can_write && !start_read;
    // read data taken at the last low cycle, after access time and two stages
    wire capture = (state == ST_RD_LOW) && (cnt == '0);

    // next state
    always_comb begin
        next_state = state;
        // phase counter runs down to zero and rests there
        next_cnt = (cnt == '0) ? cnt : cnt - 1'b1;
        case (state)
            ST_RESET_LOW: begin
                if (cnt == '0) begin
                    next_state = ST_RESET_REC;
                    next_cnt = afex_pkg::CNT_W'(afex_pkg::RESET_REC_CYC - 1);
                end
            end
            ST_RESET_REC: begin
                if (cnt == '0) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // reset first, then retransmit, then data traffic
                if (take_reset) begin
                    next_state = ST_RESET_LOW;
                    next_cnt = afex_pkg::CNT_W'(afex_pkg::RESET_LOW_CYC - 1);
                end else if (take_rt) begin
                    next_state = ST_RT_LOW;
                    next_cnt = afex_pkg::CNT_W'(afex_pkg::RETRANSMIT_LOW_CYC - 1);
                end else if (start_read) begin
                    next_state = ST_RD_LOW;
                    next_cnt = afex_pkg::CNT_W'(afex_pkg::READ_LOW_CYC - 1);
                end else if (start_write) begin
                    next_state = ST_WR_LOW;
                    next_cnt = afex_pkg::CNT_W'(afex_pkg::WRITE_LOW_CYC - 1);
                end
            end
            ST_WR_LOW: begin
                if (cnt == '0) begin
                    next_state = ST_WR_HIGH;
                    next_cnt = afex_pkg::CNT_W'(afex_pkg::SETTLE_CYC - 1);
                end
            end
            ST_RD_LOW: begin
                if (cnt == '0) begin
                    next_state = ST_RD_HIGH;
                    next_cnt = afex_pkg::CNT_W'(afex_pkg::SETTLE_CYC - 1);
                end
            end
            ST_RT_LOW: begin
                if (cnt == '0) begin
                    next_state = ST_RT_HIGH;
                    next_cnt = afex_pkg::CNT_W'(afex_pkg::SETTLE_CYC - 1);
                end
            end
            ST_WR_HIGH, ST_RD_HIGH, ST_RT_HIGH: begin
                if (cnt == '0) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_RESET_LOW;
                next_cnt = afex_pkg::CNT_W'(afex_pkg::RESET_LOW_CYC - 1);
            end
        endcase
    end

    // pin levels that follow the next state
    wire next_reset_n = (next_state != ST_RESET_LOW);
    wire next_write_n = (next_state != ST_WR_LOW);
    wire next_read_n = (next_state != ST_RD_LOW);
    wire [afex_pkg::NUM_DEV-1:0] flrt_depth = afex_pkg::FLRT_FIRST_ONLY;
    wire [afex_pkg::NUM_DEV-1:0] flrt_other = (next_state == ST_RT_LOW) ?
        afex_pkg::FLRT_ALL_LOW : afex_pkg::FLRT_ALL_HIGH;
    wire [afex_pkg::NUM_DEV-1:0] next_flrt = depth_mode ? flrt_depth : flrt_other;
    // outside width mode only lane 0 carries data; copying it keeps every lane defined
    wire [afex_pkg::WORD_W-1:0] lane_copy = {afex_pkg::NUM_DEV{buf_data[afex_pkg::LANE_W-1:0]}};
    wire [afex_pkg::WORD_W-1:0] next_data = width_mode ? buf_data : lane_copy;
    // single and depth modes return the nine-bit lane 0 word, zero-extended
    wire [afex_pkg::WORD_W-1:0] q_word = width_mode ? q_s2 :
        {{(afex_pkg::WORD_W-afex_pkg::LANE_W){1'b0}}, q_s2[afex_pkg::LANE_W-1:0]};

    // state and phase counter
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state <= ST_RESET_LOW;
            cnt <= afex_pkg::CNT_W'(afex_pkg::RESET_LOW_CYC - 1);
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // mode is taken only while the devices are held in reset
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            mode <= afex_pkg::AFEX_MODE_SINGLE;
        end else if (state == ST_RESET_LOW) begin
            mode <= mode_in;
        end
    end

    // one process owns the whole pin bundle; registered strobes never glitch
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            pins.reset_strobe_n <= 1'b0;
            pins.write_n <= 1'b1;
            pins.read_n <= 1'b1;
            pins.first_load_or_retransmit_n <= afex_pkg::FLRT_ALL_HIGH;
            pins.data <= afex_pkg::DATA_RESET;
        end else begin
            pins.reset_strobe_n <= next_reset_n;
            pins.write_n <= next_write_n;
            pins.read_n <= next_read_n;
            pins.first_load_or_retransmit_n <= next_flrt;
            // write data held stable across the whole strobe
            if (start_write) begin
                pins.data <= next_data;
            end
        end
    end

    // two-stage synchronisers for flags and read data
    // read data only move at the read strobe edges and hold while read is low, so the word is stable when captured
    always_ff @(posedge clk_sys_in) begin
        flags_s1 <= dev_flags_in;
        flags_s2 <= flags_s1;
        q_s1 <= dev_q_in;
        q_s2 <= q_s1;
    end

    // one-word holding register towards the consumer
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rd_data <= afex_pkg::DATA_RESET;
        end else if (capture) begin
            rd_data <= q_word;
        end
    end

    // capture wins over the consumer's take
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rd_valid <= 1'b0;
        end else if (capture) begin
            rd_valid <= 1'b1;
        end else if (rd_ready_in) begin
            rd_valid <= 1'b0;
        end
    end

    // pending requests; a new request beats the clear
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            reset_pend <= 1'b0;
            rt_pend <= 1'b0;
        end else begin
            reset_pend <= reset_req_in || (reset_pend && !take_reset);
            rt_pend <= retransmit_req_in || (rt_pend && !take_rt && !drop_rt);
        end
    end

    // after a write the next free slot goes to a read
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            prefer_read <= 1'b0;
            rt_refused <= 1'b0;
        end else begin
            prefer_read <= start_write || (prefer_read && !start_read);
            rt_refused <= drop_rt;
        end
    end

    // flag outputs frozen to reset values while the devices are in reset
    wire in_reset = (state == ST_RESET_LOW) || (state == ST_RESET_REC);

    assign dev_pins_out = pins;
    // strap grounds chain-in outside depth mode; in depth mode the chain wiring owns it
    assign chain_strap_n_out = 1'b0;
    assign chain_strap_oe_out = !depth_mode;
    assign empty_out = in_reset || !comp_empty_n;
    assign full_out = !in_reset && !comp_full_n;
    assign half_full_out = !in_reset && !comp_half_n;
    assign rd_valid_out = rd_valid;
    assign rd_data_out = rd_data;
    assign retransmit_refused_out = rt_refused;
    assign busy_out = !idle;
endmodule // afex_host_ctrl
`default_nettype wire

// *** rtl/afex_pkg.sv ***
// constants, types and pin bundles of the fifo expansion host controller
`default_nettype none
package afex_pkg;
    localparam int NUM_DEV = 2;
    localparam int LANE_W = 9;
    localparam int WORD_W = NUM_DEV * LANE_W;
    localparam int BUF_DEPTH = 8;
    localparam int SYNC_STAGES = 2;

    // timing of the device strobes, ns; least times, rounded up to cycles
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_RESET_LOW_NS = 40;
    localparam int T_RESET_REC_NS = 20;
    localparam int T_WRITE_LOW_NS = 30;
    localparam int T_READ_ACCESS_DELAY_NS = 25;
    localparam int T_RETRANSMIT_LOW_NS = 30;
    localparam int T_RECOVERY_NS = 20;
    localparam int T_FLAG_NS = 30;

    localparam int RESET_LOW_CYC = (T_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_REC_CYC = (T_RESET_REC_NS + T_FLAG_NS + 2 * CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
        + SYNC_STAGES;
    localparam int WRITE_LOW_CYC = (T_WRITE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_LOW_CYC = (T_READ_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
    localparam int RETRANSMIT_LOW_CYC = (T_RETRANSMIT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (T_RECOVERY_NS + T_FLAG_NS + 2 * CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
        + SYNC_STAGES;

    localparam int CNT_W = 5;

    typedef enum logic [1:0] {
        AFEX_MODE_SINGLE,
        AFEX_MODE_WIDTH,
        AFEX_MODE_DEPTH
    } afex_mode_t;

    // pins that the host drives into every device, strobes common to all except first load/retransmit, which has one bit per device
    typedef struct packed {
        logic reset_strobe_n;
        logic write_n;
        logic read_n;
        logic [NUM_DEV-1:0] first_load_or_retransmit_n;
        logic [WORD_W-1:0] data;
    } afex_pins_t;

    // flags that the devices drive back, one bit per device
    typedef struct packed {
        logic [NUM_DEV-1:0] empty_flag_n;
        logic [NUM_DEV-1:0] full_flag_n;
        logic [NUM_DEV-1:0] chain_out_n;
    } afex_flags_t;

    localparam logic [NUM_DEV-1:0] FLRT_ALL_HIGH = {NUM_DEV{1'b1}};
    localparam logic [NUM_DEV-1:0] FLRT_ALL_LOW = {NUM_DEV{1'b0}};
    localparam logic [NUM_DEV-1:0] FLRT_FIRST_ONLY = {{(NUM_DEV-1){1'b1}}, 1'b0};
    localparam logic [WORD_W-1:0] DATA_RESET = {WORD_W{1'b0}};
endpackage
`default_nettype wire

// *** rtl/afex_buf.sv ***
// small fifo buffer with valid/ready on both sides
`default_nettype none
module afex_buf #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;
    wire [AW-1:0] wr_ptr_inc = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    wire [AW-1:0] rd_ptr_inc = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

    assign in_ready_out = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr_inc;
            end
            if (pop) begin
                rd_ptr <= rd_ptr_inc;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // afex_buf
`default_nettype wire

// *** bench/afex_host_ctrl_properties.sv ***
// port assertions of the fifo expansion host controller
`default_nettype none
module afex_host_ctrl_properties (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire afex_pkg::afex_pins_t dev_pins_out,
    input wire afex_pkg::afex_flags_t dev_flags_in,
    input wire logic empty_out,
    input wire logic full_out,
    input wire logic half_full_out,
    input wire logic retransmit_refused_out,
    input wire logic chain_strap_oe_out,
    input wire logic busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    wire logic wr_n = dev_pins_out.write_n;
    wire logic rd_n = dev_pins_out.read_n;
    wire logic rs_n = dev_pins_out.reset_strobe_n;
    wire logic [afex_pkg::NUM_DEV-1:0] flrt = dev_pins_out.first_load_or_retransmit_n;
    sequence s_wr_pulse;
        (!wr_n) [*3] ##1 wr_n;
    endsequence
    sequence s_rd_pulse;
        (!rd_n) [*5] ##1 rd_n;
    endsequence
    sequence s_rs_pulse;
        (!rs_n) [*4] ##1 rs_n;
    endsequence
    sequence s_rt_pulse;
        (flrt == afex_pkg::FLRT_ALL_LOW) [*3] ##1 (flrt == afex_pkg::FLRT_ALL_HIGH);
    endsequence
    a_write_len: assert property ($fell(wr_n) |-> s_wr_pulse)
        else $error("write strobe width wrong");
    a_write_not_full: assert property ($fell(wr_n) |-> !$past(full_out))
        else $error("write started while full");
    a_read_not_empty: assert property ($fell(rd_n) |-> !$past(empty_out))
        else $error("read started while empty");
    a_read_len: assert property ($fell(rd_n) |-> s_rd_pulse)
        else $error("read strobe width wrong");
    a_reset_len: assert property ($fell(rs_n) |-> s_rs_pulse)
        else $error("reset strobe width wrong");
    a_reset_quiet: assert property (!rs_n |-> wr_n && rd_n)
        else $error("strobe active during reset");
    a_retrans_len: assert property ($fell(flrt[1]) |-> chain_strap_oe_out ##0 s_rt_pulse)
        else $error("retransmit pulse wrong");
    a_first_load: assert property (!chain_strap_oe_out && !$past(chain_strap_oe_out) && !$past(sys_rst_in)
        |-> flrt == afex_pkg::FLRT_FIRST_ONLY)
        else $error("first load pins wrong in depth mode");
    a_depth_no_half: assert property (!chain_strap_oe_out |-> !half_full_out)
        else $error("half full shown in depth mode");
    a_refuse_depth: assert property (retransmit_refused_out |-> !chain_strap_oe_out)
        else $error("retransmit refused outside depth mode");
    a_empty_comp: assert property (empty_out && !busy_out && !chain_strap_oe_out
        |-> !(|$past(dev_flags_in.empty_flag_n, 2)))
        else $error("composite empty without all devices empty");
    a_full_comp: assert property (full_out && !busy_out && !chain_strap_oe_out
        |-> !(|$past(dev_flags_in.full_flag_n, 2)))
        else $error("composite full without all devices full");
endmodule // afex_host_ctrl_properties
bind afex_host_ctrl afex_host_ctrl_properties chk_u (.clk_sys_in, .sys_rst_in, .dev_pins_out, .dev_flags_in,
    .empty_out, .full_out, .half_full_out, .retransmit_refused_out, .chain_strap_oe_out, .busy_out);
`default_nettype wire

// *** bench/afex_dev_model.sv ***
// behavioural model of the fifo devices driven by the host controller
`default_nettype none
module afex_dev_model #(
    parameter int DEPTH = 4
) (
    input wire afex_pkg::afex_pins_t pins_in,
    input wire logic chain_in_n_in,
    output afex_pkg::afex_flags_t flags_out,
    output logic [afex_pkg::WORD_W-1:0] q_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [afex_pkg::WORD_W-1:0] mem [DEPTH];
    logic [afex_pkg::WORD_W-1:0] last_q = 18'h0;
    int wp = 0;
    int rp = 0;
    int cnt = 0;
    // strobes are common, so all lanes share one pointer state
    always @(negedge pins_in.reset_strobe_n) begin
        wp = 0;
        rp = 0;
        cnt = 0;
    end
    always @(posedge pins_in.write_n) begin
        if (pins_in.reset_strobe_n && cnt < DEPTH) begin
            mem[wp] = pins_in.data;
            wp = (wp + 1) % DEPTH;
            cnt++;
        end
    end
    always @(posedge pins_in.read_n) begin
        if (cnt > 0) begin
            last_q = mem[rp];
            rp = (rp + 1) % DEPTH;
            cnt--;
        end
    end
    // in a chain the pin means first load, so no retransmit
    always @(negedge pins_in.first_load_or_retransmit_n[0]) begin
        if (!chain_in_n_in && pins_in.reset_strobe_n) begin
            rp = 0;
            cnt = wp;
        end
    end
    assign flags_out.empty_flag_n = {afex_pkg::NUM_DEV{cnt != 0}};
    assign flags_out.full_flag_n = {afex_pkg::NUM_DEV{cnt != DEPTH}};
    // in a chain the pin marks the last location instead of half full
    assign flags_out.chain_out_n = {afex_pkg::NUM_DEV{chain_in_n_in ? (wp != DEPTH - 1) : (cnt <= DEPTH / 2)}};
    // released outputs show the inverse of the last word
    assign q_out = pins_in.read_n ? ~last_q : mem[rp];
endmodule // afex_dev_model
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench of the fifo expansion host controller
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        afex_pkg::afex_mode_t mode;
        logic [afex_pkg::WORD_W-1:0] wd;
        logic [afex_pkg::WORD_W-1:0] rd;
        logic [afex_pkg::NUM_DEV-1:0] flrt;
        logic oe;
    } afex_row_t;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    afex_pkg::afex_mode_t mode_in = afex_pkg::AFEX_MODE_SINGLE;
    logic reset_req_in = 1'b0;
    logic retransmit_req_in = 1'b0;
    logic wr_valid_in = 1'b0;
    logic [afex_pkg::WORD_W-1:0] wr_data_in = 18'h0;
    logic rd_ready_in = 1'b0;
    logic wr_ready_out;
    logic rd_valid_out;
    logic [afex_pkg::WORD_W-1:0] rd_data_out;
    logic [afex_pkg::WORD_W-1:0] dev_q_in;
    afex_pkg::afex_pins_t dev_pins_out;
    afex_pkg::afex_flags_t dev_flags_in;
    logic chain_strap_n_out;
    logic chain_strap_oe_out;
    logic empty_out;
    logic full_out;
    logic half_full_out;
    logic retransmit_refused_out;
    logic busy_out;
    logic chain_in_n;
    wire logic [4:0] pin_view = {dev_pins_out.reset_strobe_n, dev_pins_out.write_n, dev_pins_out.read_n,
        dev_pins_out.first_load_or_retransmit_n};
    int errors = 0;
    int n_checks = 0;
    afex_row_t rows [4] = '{
        '{afex_pkg::AFEX_MODE_SINGLE, 18'h3a5a5, 18'h001a5, afex_pkg::FLRT_ALL_HIGH, 1'b1},
        '{afex_pkg::AFEX_MODE_WIDTH, 18'h3a5a5, 18'h3a5a5, afex_pkg::FLRT_ALL_HIGH, 1'b1},
        '{afex_pkg::AFEX_MODE_WIDTH, 18'h3ffff, 18'h3ffff, afex_pkg::FLRT_ALL_HIGH, 1'b1},
        '{afex_pkg::AFEX_MODE_DEPTH, 18'h2ff01, 18'h00101, afex_pkg::FLRT_FIRST_ONLY, 1'b0}};

    always #5 clk_sys_in = ~clk_sys_in;
    // strap drives the chain pin when enabled, pulled high otherwise
    assign chain_in_n = chain_strap_oe_out ? chain_strap_n_out : 1'b1;
    afex_host_ctrl dut_u (.clk_sys_in, .sys_rst_in, .mode_in, .reset_req_in, .retransmit_req_in, .wr_valid_in,
        .wr_ready_out, .wr_data_in, .rd_valid_out, .rd_ready_in, .rd_data_out, .dev_pins_out, .dev_flags_in,
        .dev_q_in, .chain_strap_n_out, .chain_strap_oe_out, .empty_out, .full_out, .half_full_out,
        .retransmit_refused_out, .busy_out);
    afex_dev_model #(.DEPTH(4)) dev_u (.pins_in(dev_pins_out), .chain_in_n_in(chain_in_n),
        .flags_out(dev_flags_in), .q_out(dev_q_in));

    task end_of_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task too_long(input string what);
        errors++;
        $display("wrong value %s expected done seen timeout", what);
        end_of_test();
    endtask
    task wait_idle;
        int k;
        repeat (2) @(negedge clk_sys_in);
        for (k = 0; k < 200 && busy_out !== 1'b0; k++) @(negedge clk_sys_in);
        if (busy_out !== 1'b0) too_long("idle");
    endtask
    task set_mode(input afex_pkg::afex_mode_t m);
        mode_in = m;
        reset_req_in = 1'b1;
        @(negedge clk_sys_in);
        reset_req_in = 1'b0;
        wait_idle();
    endtask
    task put(input logic [afex_pkg::WORD_W-1:0] w);
        int k;
        wr_valid_in = 1'b1;
        wr_data_in = w;
        for (k = 0; k < 300 && wr_ready_out !== 1'b1; k++) @(negedge clk_sys_in);
        if (wr_ready_out !== 1'b1) too_long("write ready");
        @(negedge clk_sys_in);
    endtask
    task get(input logic [afex_pkg::WORD_W-1:0] exp);
        int k;
        for (k = 0; k < 300 && rd_valid_out !== 1'b1; k++) @(negedge clk_sys_in);
        if (rd_valid_out !== 1'b1) too_long("read valid");
        check("read data", exp, rd_data_out);
        rd_ready_in = 1'b1;
        @(negedge clk_sys_in);
        rd_ready_in = 1'b0;
    endtask
    task pulse_retransmit;
        retransmit_req_in = 1'b1;
        @(negedge clk_sys_in);
        retransmit_req_in = 1'b0;
    endtask

    initial begin
        repeat (10) @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        wait_idle();
        foreach (rows[i]) begin
            set_mode(rows[i].mode);
            put(rows[i].wd);
            wr_valid_in = 1'b0;
            get(rows[i].rd);
            check("first load", rows[i].flrt, dev_pins_out.first_load_or_retransmit_n);
            check("strap pins", {rows[i].oe, 1'b0}, {chain_strap_oe_out, chain_strap_n_out});
            $display("row %0d done", i);
        end
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        check("reset pins", 5'h0f, pin_view);
        check("reset flags", 3'h4, {empty_out, full_out, rd_valid_out});
        sys_rst_in = 1'b0;
        wait_idle();
        $display("reset test done");
        set_mode(afex_pkg::AFEX_MODE_WIDTH);
        for (int k = 0; k < 13; k++) put(18'h2a000 + 18'(k));
        wr_data_in = 18'h2a00d;
        repeat (100) @(negedge clk_sys_in);
        check("full state", 3'h6, {full_out, half_full_out, wr_ready_out});
        wr_valid_in = 1'b0;
        for (int k = 0; k < 13; k++) get(18'h2a000 + 18'(k));
        repeat (20) @(negedge clk_sys_in);
        check("empty state", 2'h2, {empty_out, full_out});
        $display("fill test done");
        set_mode(afex_pkg::AFEX_MODE_SINGLE);
        put(18'h00011);
        put(18'h00022);
        wr_valid_in = 1'b0;
        get(18'h00011);
        get(18'h00022);
        wait_idle();
        pulse_retransmit();
        get(18'h00011);
        get(18'h00022);
        $display("retransmit test done");
        set_mode(afex_pkg::AFEX_MODE_DEPTH);
        pulse_retransmit();
        for (int k = 0; k < 50 && retransmit_refused_out !== 1'b1; k++) @(negedge clk_sys_in);
        check("refused", 2'h2, {retransmit_refused_out, half_full_out});
        for (int k = 0; k < 5; k++) put(18'h00100 + 18'(k));
        wr_valid_in = 1'b0;
        repeat (100) @(negedge clk_sys_in);
        check("depth full", 3'h4, {full_out, half_full_out, empty_out});
        for (int k = 0; k < 5; k++) get(18'h00100 + 18'(k));
        $display("depth test done");
        end_of_test();
    end
endmodule // tb
`default_nettype wire
